/* File: common/sfm_cfg.svh */
`ifndef SFM_CFG_SVH
`define SFM_CFG_SVH
// register byte offsets
`define SFM_A_FEAT 8'h00
`define SFM_A_SCNT 8'h04
`define SFM_A_SNUM 8'h08
`define SFM_A_CLO 8'h0C
`define SFM_A_CHI 8'h10
`define SFM_A_DH 8'h14
`define SFM_A_CMD 8'h18
`define SFM_A_STAT 8'h1C
`define SFM_A_CTRL 8'h20
`define SFM_A_XFER 8'h24
`define SFM_A_PWR 8'h28
`define SFM_A_MAX 8'h2C
// command and subcommand codes
`define SFM_C_SETF 8'hEF
`define SFM_C_NMAX 8'hF8
`define SFM_C_SMAX 8'hF9
`define SFM_F_XFER 8'h03
`define SFM_F_APM 8'h05
`define SFM_F_APMX 8'h85
`define SFM_F_PL1 8'h0A
`define SFM_F_PL1X 8'h8A
`define SFM_F_RLA 8'h55
`define SFM_F_LONG 8'hBB
`define SFM_F_ILIM 8'h9A
`define SFM_F_PORX 8'h66
`define SFM_F_POR 8'hCC
// transfer type field
`define SFM_T_DEF 5'h00
`define SFM_T_PIO 5'h01
`define SFM_T_MDMA 5'h04
`define SFM_T_UDMA 5'h08
`define SFM_M_NOIORDY 3'h1
`define SFM_PIO_IORDY 3'h3
// set max feature codes
`define SFM_X_ADDR 8'h00
`define SFM_X_PASS 8'h01
`define SFM_X_LOCK 8'h02
`define SFM_X_UNLK 8'h03
`define SFM_X_FRZ 8'h04
// apm levels
`define SFM_APM_RSV 8'hFF
`define SFM_APM_NOSTBY 8'h80
// device capabilities and reset values
`define SFM_PIO_MAX 3'h4
`define SFM_MDMA_MAX 3'h2
`define SFM_UDMA_MAX 3'h2
`define SFM_IORDY_OFF_OK 1'b1
`define SFM_ILIM_MIN 8'h10
`define SFM_ILIM_MAX 8'h40
`define SFM_NATIVE_MAX 28'h00FFFFF
`define SFM_EXEC_CYC 4'h3
`endif

/* File: common/sfm_pkg.sv */
package sfm_pkg;
    typedef enum logic [2:0] {
        SFM_IDLE = 3'b001,
        SFM_EXEC = 3'b010,
        SFM_DONE = 3'b100
    } sfm_state_t;
endpackage

/* File: hdl/sfm_cmd.sv */
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "sfm_cfg.svh"
module sfm_cmd (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic busy,
    output logic [2:0] pio_mode,
    output logic iordy_en,
    output logic mdma_en,
    output logic udma_en,
    output logic [2:0] dma_mode,
    output logic standby_ok,
    output logic pl1_en,
    output logic [7:0] ilim_eff,
    output logic [27:0] max_addr
);
    sfm_pkg::sfm_state_t state;
    logic [7:0] feat, scnt, snum, clo, chi, dh, cmd;
    logic [3:0] cnt;
    logic aw_held, w_held, wr_ok;
    logic [7:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic err, done, pc_card_mode, soft_rst, hw_rst;
    logic iordy_off, apm_en, por_on_soft;
    logic [7:0] apm_level, ilim;
    logic [27:0] nv_max;
    logic native_ok, nv_set, pass_set, locked, frozen;
    logic go, wr_fire, cmd_wr, ok;
    logic [4:0] xtype;
    logic [2:0] xmode;
    logic [27:0] new_max, native_max;

    assign xtype = scnt[7:3];
    assign xmode = scnt[2:0];
    assign new_max = {dh[3:0], chi, clo, snum};
    assign native_max = `SFM_NATIVE_MAX;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign cmd_wr = wr_fire && aw_a == `SFM_A_CMD && w_s[0];
    assign go = cmd_wr && state == sfm_pkg::SFM_IDLE;
    assign busy = state != sfm_pkg::SFM_IDLE;

    // write channel: address and data taken in any order
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_a <= 8'h00;
            w_d <= 32'h0000_0000;
            w_s <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_a <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_d <= s_axi_wdata;
                w_s <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        case (aw_a)
            `SFM_A_FEAT, `SFM_A_SCNT, `SFM_A_SNUM, `SFM_A_CLO, `SFM_A_CHI,
            `SFM_A_DH, `SFM_A_CMD, `SFM_A_STAT, `SFM_A_CTRL: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `SFM_A_FEAT: s_axi_rdata <= {24'h0, feat};
                `SFM_A_SCNT: s_axi_rdata <= {24'h0, scnt};
                `SFM_A_SNUM: s_axi_rdata <= {24'h0, snum};
                `SFM_A_CLO: s_axi_rdata <= {24'h0, clo};
                `SFM_A_CHI: s_axi_rdata <= {24'h0, chi};
                `SFM_A_DH: s_axi_rdata <= {24'h0, dh};
                `SFM_A_CMD: s_axi_rdata <= {24'h0, cmd};
                `SFM_A_STAT: s_axi_rdata <= {25'h0, frozen, locked, pass_set,
                    done, err, !busy, busy};
                `SFM_A_CTRL: s_axi_rdata <= {28'h0, por_on_soft, 2'h0, pc_card_mode};
                `SFM_A_XFER: s_axi_rdata <= {20'h0, iordy_en, dma_mode, udma_en,
                    mdma_en, 3'h0, pio_mode};
                `SFM_A_PWR: s_axi_rdata <= {ilim, 12'h000, pl1_en, standby_ok,
                    apm_en, 1'b0, apm_level};
                `SFM_A_MAX: s_axi_rdata <= {4'h0, max_addr};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // control register: mode strap level, reset pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_card_mode <= 1'b0;
            soft_rst <= 1'b0;
            hw_rst <= 1'b0;
        end else begin
            soft_rst <= 1'b0;
            hw_rst <= 1'b0;
            if (wr_fire && aw_a == `SFM_A_CTRL && w_s[0]) begin
                pc_card_mode <= w_d[0];
                soft_rst <= w_d[1];
                hw_rst <= w_d[2];
            end
        end
    end

    // command sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= sfm_pkg::SFM_IDLE;
            cnt <= 4'h0;
        end else begin
            case (state)
                sfm_pkg::SFM_IDLE: begin
                    if (go) begin
                        state <= sfm_pkg::SFM_EXEC;
                        cnt <= `SFM_EXEC_CYC;
                    end
                end
                sfm_pkg::SFM_EXEC: begin
                    cnt <= cnt - 4'h1;
                    if (cnt == 4'h1) begin
                        state <= sfm_pkg::SFM_DONE;
                    end
                end
                sfm_pkg::SFM_DONE: state <= sfm_pkg::SFM_IDLE;
                default: state <= sfm_pkg::SFM_IDLE;
            endcase
        end
    end

    // decision on the latched task file
    always_comb begin
        ok = 1'b1;
        case (cmd)
            `SFM_C_SETF: begin
                case (feat)
                    `SFM_F_XFER: begin
                        case (xtype)
                            `SFM_T_DEF: ok = xmode == 3'h0 ||
                                (xmode == `SFM_M_NOIORDY && `SFM_IORDY_OFF_OK);
                            `SFM_T_PIO: ok = xmode <= `SFM_PIO_MAX;
                            `SFM_T_MDMA: ok = !pc_card_mode &&
                                xmode <= `SFM_MDMA_MAX;
                            `SFM_T_UDMA: ok = xmode <= `SFM_UDMA_MAX;
                            default: ok = 1'b0;
                        endcase
                    end
                    `SFM_F_APM: ok = scnt != 8'h00 && scnt != `SFM_APM_RSV;
                    `SFM_F_APMX, `SFM_F_PL1, `SFM_F_PL1X, `SFM_F_RLA, `SFM_F_LONG,
                    `SFM_F_ILIM, `SFM_F_PORX, `SFM_F_POR: ok = 1'b1;
                    default: ok = 1'b0;
                endcase
            end
            `SFM_C_NMAX: ok = 1'b1;
            `SFM_C_SMAX: begin
                case (feat)
                    `SFM_X_ADDR: ok = native_ok && dh[6] && !locked && !frozen &&
                        !(scnt[0] && nv_set);
                    `SFM_X_PASS, `SFM_X_LOCK: ok = !frozen;
                    `SFM_X_UNLK: ok = !frozen;
                    `SFM_X_FRZ: ok = 1'b1;
                    default: ok = 1'b0;
                endcase
            end
            default: ok = 1'b0;
        endcase
    end

    // task file and completion status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {feat, scnt, snum, clo, chi, dh, cmd} <= 56'h0;
            err <= 1'b0;
            done <= 1'b0;
        end else begin
            if (wr_fire && w_s[0] && !busy) begin
                case (aw_a)
                    `SFM_A_FEAT: feat <= w_d[7:0];
                    `SFM_A_SCNT: scnt <= w_d[7:0];
                    `SFM_A_SNUM: snum <= w_d[7:0];
                    `SFM_A_CLO: clo <= w_d[7:0];
                    `SFM_A_CHI: chi <= w_d[7:0];
                    `SFM_A_DH: dh <= w_d[7:0];
                    `SFM_A_CMD: cmd <= w_d[7:0];
                    default: ;
                endcase
            end
            if (wr_fire && aw_a == `SFM_A_STAT && w_s[0] && w_d[3]) begin
                done <= 1'b0;
            end
            if (go) begin
                err <= 1'b0;
            end
            if (state == sfm_pkg::SFM_DONE) begin
                done <= 1'b1;
                err <= !ok;
                if (ok && cmd == `SFM_C_SETF && feat == `SFM_F_ILIM) begin
                    clo <= `SFM_ILIM_MIN;
                    chi <= `SFM_ILIM_MAX;
                end
                if (ok && cmd == `SFM_C_NMAX) begin
                    snum <= native_max[7:0];
                    clo <= native_max[15:8];
                    chi <= native_max[23:16];
                    dh <= {dh[7:4], native_max[27:24]};
                end
            end
        end
    end

    // transfer mode settings
    always_ff @(posedge aclk) begin
        if (!aresetn || (soft_rst && por_on_soft)) begin
            pio_mode <= 3'h0;
            iordy_off <= 1'b0;
            mdma_en <= 1'b0;
            udma_en <= 1'b0;
            dma_mode <= 3'h0;
        end else if (state == sfm_pkg::SFM_DONE && ok && cmd == `SFM_C_SETF &&
                     feat == `SFM_F_XFER) begin
            case (xtype)
                `SFM_T_DEF: begin
                    pio_mode <= 3'h0;
                    iordy_off <= xmode == `SFM_M_NOIORDY;
                end
                `SFM_T_PIO: begin
                    pio_mode <= xmode;
                    iordy_off <= 1'b0;
                end
                `SFM_T_MDMA: begin
                    mdma_en <= 1'b1;
                    udma_en <= 1'b0;
                    dma_mode <= xmode;
                end
                `SFM_T_UDMA: begin
                    udma_en <= 1'b1;
                    mdma_en <= 1'b0;
                    dma_mode <= xmode;
                end
                default: ;
            endcase
        end else if (pc_card_mode) begin
            mdma_en <= 1'b0;
        end
    end
    assign iordy_en = !iordy_off || pio_mode >= `SFM_PIO_IORDY;

    // power settings; apm level only sets standby_ok, no effect on speed
    always_ff @(posedge aclk) begin
        if (!aresetn || (soft_rst && por_on_soft)) begin
            apm_en <= 1'b0;
            apm_level <= 8'h00;
            pl1_en <= 1'b0;
            ilim <= `SFM_ILIM_MAX;
        end else if (state == sfm_pkg::SFM_DONE && ok && cmd == `SFM_C_SETF) begin
            case (feat)
                `SFM_F_APM: begin
                    apm_en <= 1'b1;
                    apm_level <= scnt;
                end
                `SFM_F_APMX: apm_en <= 1'b0;
                `SFM_F_PL1: pl1_en <= 1'b1;
                `SFM_F_PL1X: pl1_en <= 1'b0;
                `SFM_F_ILIM: ilim <= scnt;
                default: ;
            endcase
        end
    end
    assign standby_ok = !apm_en || apm_level < `SFM_APM_NOSTBY;
    assign ilim_eff = ilim < `SFM_ILIM_MIN ? `SFM_ILIM_MIN :
        ilim > `SFM_ILIM_MAX ? `SFM_ILIM_MAX : ilim;

    // soft reset restore choice survives soft reset itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_on_soft <= 1'b1;
        end else if (state == sfm_pkg::SFM_DONE && ok && cmd == `SFM_C_SETF) begin
            if (feat == `SFM_F_PORX) begin
                por_on_soft <= 1'b0;
            end else if (feat == `SFM_F_POR) begin
                por_on_soft <= 1'b1;
            end
        end
    end

    // max address, lock state and prerequisite tracking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            max_addr <= `SFM_NATIVE_MAX;
            nv_max <= `SFM_NATIVE_MAX;
            native_ok <= 1'b0;
            nv_set <= 1'b0;
            pass_set <= 1'b0;
            locked <= 1'b0;
            frozen <= 1'b0;
        end else if (hw_rst) begin
            max_addr <= nv_max;
            native_ok <= 1'b0;
            nv_set <= 1'b0;
            locked <= 1'b0;
            frozen <= 1'b0;
        end else if (state == sfm_pkg::SFM_DONE) begin
            native_ok <= ok && cmd == `SFM_C_NMAX;
            if (ok && cmd == `SFM_C_SMAX) begin
                case (feat)
                    `SFM_X_ADDR: begin
                        max_addr <= new_max;
                        if (scnt[0]) begin
                            nv_max <= new_max;
                            nv_set <= 1'b1;
                        end
                    end
                    `SFM_X_PASS: pass_set <= 1'b1;
                    `SFM_X_LOCK: locked <= 1'b1;
                    `SFM_X_UNLK: locked <= 1'b0;
                    `SFM_X_FRZ: frozen <= 1'b1;
                    default: ;
                endcase
            end
        end
    end
endmodule

/* File: verif/sfm_cmd_checker.sv */
`timescale 1ns/1ps
`include "sfm_cfg.svh"
module sfm_cmd_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic busy,
    input wire logic [2:0] pio_mode,
    input wire logic iordy_en,
    input wire logic mdma_en,
    input wire logic udma_en,
    input wire logic [2:0] dma_mode,
    input wire logic pl1_en,
    input wire logic [7:0] ilim_eff,
    input wire logic [27:0] max_addr
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_dma_one_type: assert property (!(mdma_en && udma_en))
        else $error("both dma types enabled");
    a_iordy_pio3: assert property (pio_mode >= `SFM_PIO_IORDY |-> iordy_en)
        else $error("iordy off at high pio mode");
    a_mode_limit: assert property (pio_mode <= `SFM_PIO_MAX)
        else $error("pio mode above maximum");
    a_dma_limit: assert property ((mdma_en || udma_en) |-> dma_mode <= `SFM_UDMA_MAX)
        else $error("dma mode above maximum");
    a_ilim_clamp: assert property (ilim_eff inside {[`SFM_ILIM_MIN:`SFM_ILIM_MAX]})
        else $error("current limit outside range");
    a_busy_span: assert property ($rose(busy) |-> busy [*4] ##1 !busy)
        else $error("busy length wrong");
    a_dma_at_done: assert property ($rose(udma_en) || $rose(mdma_en) |-> $fell(busy))
        else $error("dma enabled outside completion");
    a_reset_values: assert property (!$past(aresetn) |-> !pl1_en &&
        ilim_eff == `SFM_ILIM_MAX && max_addr == `SFM_NATIVE_MAX)
        else $error("wrong value after reset");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    c_udma: cover property ($rose(udma_en));
    c_mdma: cover property ($rose(mdma_en));
    c_pl1: cover property ($rose(pl1_en));
endmodule

/* File: verif/sfm_host.sv */
`timescale 1ns/1ps
module sfm_host (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    logic tmo = 1'b0;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic fin;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fin = 1'b0;
        n = 0;
        r = 2'h3;
        while (!fin && n < 200) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                fin = 1'b1;
            end
        end
        if (!fin)
            tmo = 1'b1;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic fin;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        fin = 1'b0;
        n = 0;
        r = 2'h3;
        while (!fin && n < 200) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                fin = 1'b1;
            end
        end
        if (!fin)
            tmo = 1'b1;
    endtask
endmodule

/* File: verif/sfm_cmd_tb_top.sv */
`timescale 1ns/1ps
`include "sfm_cfg.svh"
module sfm_cmd_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr, ilim_eff;
    logic [31:0] s_axi_wdata, s_axi_rdata, st, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic busy, iordy_en, mdma_en, udma_en, standby_ok, pl1_en;
    logic [2:0] pio_mode, dma_mode;
    logic [27:0] max_addr;
    int error_cnt = 0;
    int comparisons = 0;
    always #5 aclk = ~aclk;
    sfm_cmd DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy, .pio_mode,
        .iordy_en, .mdma_en, .udma_en, .dma_mode, .standby_ok, .pl1_en, .ilim_eff,
        .max_addr);
    sfm_host h (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    task finish_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task bail();
        error_cnt++;
        finish_test();
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        h.wr(a, d, resp);
        if (h.tmo)
            bail();
    endtask
    task rd(input logic [7:0] a);
        h.rd(a, rv, resp);
        if (h.tmo)
            bail();
    endtask
    task settle();
        repeat (2) @(posedge aclk);
        #1;
    endtask
    task cmd(input logic [7:0] f, input logic [7:0] sc, input logic [7:0] c);
        int n;
        wr(`SFM_A_FEAT, {24'h0, f});
        wr(`SFM_A_SCNT, {24'h0, sc});
        wr(`SFM_A_CMD, {24'h0, c});
        #1;
        chk("busy", busy, 1'b1);
        n = 0;
        st = '0;
        while (st[3] !== 1'b1 && n < 40) begin
            rd(`SFM_A_STAT);
            st = rv;
            n++;
        end
        if (st[3] !== 1'b1)
            bail();
        chk("busy_end", busy, 1'b0);
        wr(`SFM_A_STAT, 32'h8);
    endtask
    task xf(input logic [7:0] sc, logic e, logic [2:0] p, logic md, logic ud);
        cmd(`SFM_F_XFER, sc, `SFM_C_SETF);
        chk("xf_err", st[2], e);
        chk("pio", pio_mode, p);
        chk("mdma", mdma_en, md);
        chk("udma", udma_en, ud);
    endtask
    task nm();
        cmd(8'h00, 8'h00, `SFM_C_NMAX);
    endtask
    task sm(input logic [7:0] f, logic [7:0] sc, logic [27:0] a);
        wr(`SFM_A_SNUM, {24'h0, a[7:0]});
        wr(`SFM_A_CLO, {24'h0, a[15:8]});
        wr(`SFM_A_CHI, {24'h0, a[23:16]});
        wr(`SFM_A_DH, {24'h0, 4'h4, a[27:24]});
        cmd(f, sc, `SFM_C_SMAX);
    endtask
    task t_reset();
        chk("pl1_rst", pl1_en, 1'b0);
        chk("ilim_rst", ilim_eff, `SFM_ILIM_MAX);
        chk("stby_rst", standby_ok, 1'b1);
        rd(`SFM_A_CTRL);
        chk("por_soft", rv[3], 1'b1);
        rd(8'h40);
        chk("unmapped", resp, 2'h2);
        wr(`SFM_A_XFER, 32'h0);
        chk("ro_write", resp, 2'h2);
        cmd(`SFM_F_RLA, 8'h00, `SFM_C_SETF);
        chk("rla", st[2], 1'b0);
        cmd(`SFM_F_LONG, 8'h00, `SFM_C_SETF);
        chk("long", st[2], 1'b0);
        $display("t_reset done");
    endtask
    task t_xfer();
        for (int m = 0; m <= 4; m++)
            xf({5'h01, m[2:0]}, 1'b0, m[2:0], 1'b0, 1'b0);
        chk("iordy4", iordy_en, 1'b1);
        xf(8'h01, 1'b0, 3'h0, 1'b0, 1'b0);
        chk("iordy_off", iordy_en, 1'b0);
        xf(8'h00, 1'b0, 3'h0, 1'b0, 1'b0);
        xf(8'h0B, 1'b0, 3'h3, 1'b0, 1'b0);
        chk("iordy3", iordy_en, 1'b1);
        for (int m = 0; m <= 2; m++) begin
            xf({5'h04, m[2:0]}, 1'b0, 3'h3, 1'b1, 1'b0);
            chk("dmode", dma_mode, m[2:0]);
        end
        xf(8'h42, 1'b0, 3'h3, 1'b0, 1'b1);
        xf(8'h43, 1'b1, 3'h3, 1'b0, 1'b1);
        xf(8'h10, 1'b1, 3'h3, 1'b0, 1'b1);
        xf(8'h21, 1'b0, 3'h3, 1'b1, 1'b0);
        wr(`SFM_A_CTRL, 32'h1);
        settle();
        chk("pc_mdma", mdma_en, 1'b0);
        xf(8'h21, 1'b1, 3'h3, 1'b0, 1'b0);
        rd(`SFM_A_XFER);
        chk("xfer_reg", rv, 32'h0000_0903);
        wr(`SFM_A_CTRL, 32'h0);
        $display("t_xfer done");
    endtask
    task t_power();
        cmd(`SFM_F_APM, 8'h7F, `SFM_C_SETF);
        chk("stby_7f", standby_ok, 1'b1);
        cmd(`SFM_F_APM, 8'h80, `SFM_C_SETF);
        chk("stby_80", standby_ok, 1'b0);
        cmd(`SFM_F_APM, 8'hFE, `SFM_C_SETF);
        chk("apm_fe", st[2], 1'b0);
        cmd(`SFM_F_APM, 8'hFF, `SFM_C_SETF);
        chk("apm_ff", st[2], 1'b1);
        cmd(`SFM_F_APM, 8'h00, `SFM_C_SETF);
        chk("apm_00", st[2], 1'b1);
        rd(`SFM_A_PWR);
        chk("pwr", {rv[9], rv[7:0]}, 9'h1FE);
        chk("pio_same", pio_mode, 3'h3);
        cmd(`SFM_F_APMX, 8'h00, `SFM_C_SETF);
        chk("stby_off", standby_ok, 1'b1);
        cmd(`SFM_F_PL1, 8'h00, `SFM_C_SETF);
        chk("pl1_on", pl1_en, 1'b1);
        cmd(`SFM_F_PL1X, 8'h00, `SFM_C_SETF);
        chk("pl1_off", pl1_en, 1'b0);
        cmd(`SFM_F_ILIM, 8'h06, `SFM_C_SETF);
        chk("ilim_lo", ilim_eff, `SFM_ILIM_MIN);
        rd(`SFM_A_CLO);
        chk("ilim_min", rv[7:0], `SFM_ILIM_MIN);
        rd(`SFM_A_CHI);
        chk("ilim_max", rv[7:0], `SFM_ILIM_MAX);
        cmd(`SFM_F_ILIM, 8'h20, `SFM_C_SETF);
        chk("ilim_mid", ilim_eff, 8'h20);
        cmd(`SFM_F_ILIM, 8'hFF, `SFM_C_SETF);
        chk("ilim_hi", ilim_eff, `SFM_ILIM_MAX);
        rd(`SFM_A_PWR);
        chk("lim_reg", rv[31:24], 8'hFF);
        $display("t_power done");
    endtask
    task t_soft();
        xf(8'h0C, 1'b0, 3'h4, 1'b0, 1'b0);
        wr(`SFM_A_CTRL, 32'h2);
        settle();
        chk("soft_def", pio_mode, 3'h0);
        cmd(`SFM_F_PORX, 8'h00, `SFM_C_SETF);
        rd(`SFM_A_CTRL);
        chk("por_off", rv[3], 1'b0);
        xf(8'h0C, 1'b0, 3'h4, 1'b0, 1'b0);
        wr(`SFM_A_CTRL, 32'h2);
        settle();
        chk("soft_keep", pio_mode, 3'h4);
        cmd(`SFM_F_POR, 8'h00, `SFM_C_SETF);
        $display("t_soft done");
    endtask
    task t_max();
        sm(`SFM_X_ADDR, 8'h00, 28'h0012345);
        chk("no_nmax", st[2], 1'b1);
        nm();
        rd(`SFM_A_CHI);
        chk("nmax_chi", rv[7:0], 8'h0F);
        sm(`SFM_X_ADDR, 8'h00, 28'h0012345);
        chk("smax", max_addr, 28'h0012345);
        wr(`SFM_A_CTRL, 32'h4);
        settle();
        chk("vol_lost", max_addr, `SFM_NATIVE_MAX);
        nm();
        sm(`SFM_X_ADDR, 8'h01, 28'h00ABCDE);
        chk("keep_ok", st[2], 1'b0);
        nm();
        sm(`SFM_X_ADDR, 8'h01, 28'h0001111);
        chk("second", st[2], 1'b1);
        wr(`SFM_A_CTRL, 32'h4);
        settle();
        chk("keep_max", max_addr, 28'h00ABCDE);
        rd(`SFM_A_MAX);
        chk("max_reg", rv, 32'h000A_BCDE);
        nm();
        sm(`SFM_X_PASS, 8'h00, 28'h00ABCDE);
        chk("pass", st[4], 1'b1);
        nm();
        sm(`SFM_X_LOCK, 8'h00, 28'h00ABCDE);
        chk("lock", st[5], 1'b1);
        nm();
        sm(`SFM_X_ADDR, 8'h00, 28'h0000100);
        chk("locked", max_addr, 28'h00ABCDE);
        nm();
        sm(`SFM_X_UNLK, 8'h00, 28'h00ABCDE);
        chk("unlock", st[5], 1'b0);
        nm();
        sm(`SFM_X_FRZ, 8'h00, 28'h00ABCDE);
        chk("freeze", st[6], 1'b1);
        nm();
        sm(`SFM_X_LOCK, 8'h00, 28'h00ABCDE);
        chk("frozen", st[2], 1'b1);
        nm();
        sm(8'h05, 8'h00, 28'h00ABCDE);
        chk("rsv_feat", st[2], 1'b1);
        $display("t_max done");
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        t_reset();
        t_xfer();
        t_power();
        t_soft();
        t_max();
        finish_test();
    end
endmodule
bind sfm_cmd sfm_cmd_checker chk_i (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .busy,
    .pio_mode, .iordy_en, .mdma_en, .udma_en, .dma_mode, .pl1_en, .ilim_eff, .max_addr);
